// ===== mmr_defines.vh
// Constants for the move, multiply and return execute block
`ifndef MMR_DEFINES_VH
`define MMR_DEFINES_VH
`define MMR_OFF_CTRL 8'h00
`define MMR_OFF_INSTR 8'h04
`define MMR_OFF_STATUS 8'h08
`define MMR_OFF_WORKING_REG 8'h0C
`define MMR_OFF_BANK 8'h10
`define MMR_OFF_PROD 8'h14
`define MMR_OFF_CPU_STATUS_REG 8'h18
`define MMR_OFF_PC 8'h1C
`define MMR_OFF_TOS 8'h20
`define MMR_OFF_MEMADDR 8'h24
`define MMR_OFF_MEMDATA 8'h28
`define MMR_OFF_INDIR 8'h2C
`define MMR_OP_NOP 16'h0000
`define MMR_OP_RETI 16'h0005
`define MMR_OP_STWF 8'h01
`define MMR_OP_MULF 8'h34
`define MMR_OP_LDLW 8'hB0
`define MMR_OP_RETURN_WITH_LITERAL 8'hB6
`define MMR_OP_BANKL 8'hB8
`define MMR_OP_MULL 8'hBC
`define MMR_OP_BANKH 7'h5D
`define MMR_OP_NEGATE_W 7'h16
`define MMR_OP_MVFP 3'h3
`define MMR_OP_MVPF 3'h2
`define MMR_ADDR_WORKING_REG 8'h0A
`define MMR_ADDR_INDF 8'h00
`define MMR_GINTD_BIT 4
`define MMR_PH_DECODE 2'h0
`define MMR_PH_READ 2'h1
`define MMR_PH_PROC 2'h2
`define MMR_PH_WRITE 2'h3
`define MMR_RESP_OKAY 2'h0
`define MMR_RESP_SLVERR 2'h2
`endif

// ===== mmr_alu.v
// Combinational multiply and negate with flag generation
`timescale 1ns/1ps
module mmr_alu (
  input wire [7:0] w_in,
  input wire [7:0] b_in,
  output wire [15:0] product,
  output wire [7:0] neg_out,
  output wire neg_ov,
  output wire neg_c,
  output wire neg_dc,
  output wire neg_z
);
  wire [8:0] sum;
  wire [4:0] low_sum;

  assign product = {8'h00, w_in} * {8'h00, b_in};
  // Negate as (~w) + 1 so the carries match an add
  assign sum = {1'b0, ~w_in} + 9'h001;
  assign low_sum = {1'b0, ~w_in[3:0]} + 5'h01;
  assign neg_out = sum[7:0];
  assign neg_c = sum[8];
  assign neg_dc = low_sum[4];
  // Only 80h overflows: the result keeps a set sign bit
  assign neg_ov = w_in[7] & sum[7];
  assign neg_z = (sum[7:0] == 8'h00);
endmodule

// ===== mmr_core.v
// Four-phase decode and execute of moves, multiplies and returns
`timescale 1ns/1ps
`include "mmr_defines.vh"
module mmr_core #(
  parameter MEM_DEPTH = 256
) (
  input wire core_clk,
  input wire rst_n,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  output reg busy
);
  reg [7:0] mem [0:MEM_DEPTH-1];
  reg [7:0] working_reg;
  reg [7:0] bank_select_reg;
  reg [7:0] product_high;
  reg [7:0] product_low;
  reg [7:0] cpu_status_reg;
  reg [7:0] pc_high_latch;
  reg [15:0] pc;
  reg [15:0] stack_top;
  reg [7:0] indir_ptr;
  reg flag_ov, flag_c, flag_dc, flag_z;
  reg [15:0] instr;
  reg [1:0] phase;
  reg run;
  reg refetch;
  reg [7:0] mem_addr;
  reg [7:0] opa;
  reg [7:0] opb;
  reg aw_got, w_got;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  wire [7:0] f_fld = instr[7:0];
  wire [7:0] p_fld = {3'h0, instr[12:8]};
  wire is_nop = (instr == `MMR_OP_NOP);
  wire is_reti = (instr == `MMR_OP_RETI);
  wire is_stwf = (instr[15:8] == `MMR_OP_STWF);
  wire is_mulf = (instr[15:8] == `MMR_OP_MULF);
  wire is_ldlw = (instr[15:8] == `MMR_OP_LDLW);
  wire is_return_with_literal = (instr[15:8] == `MMR_OP_RETURN_WITH_LITERAL);
  wire is_bankl = (instr[15:8] == `MMR_OP_BANKL);
  wire is_mull = (instr[15:8] == `MMR_OP_MULL);
  wire is_bankh = (instr[15:9] == `MMR_OP_BANKH);
  wire is_negate_w = (instr[15:9] == `MMR_OP_NEGATE_W);
  wire is_mvfp = (instr[15:13] == `MMR_OP_MVFP);
  wire is_mvpf = (instr[15:13] == `MMR_OP_MVPF);
  wire [15:0] prod;
  wire [7:0] neg_res;
  wire n_ov, n_c, n_dc, n_z;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire [7:0] lat = aw_take ? s_axi_awaddr : aw_addr;
  wire [7:0] k = w_take ? s_axi_wdata[7:0] : w_data[7:0];

  mmr_alu u_alu (
    .w_in(working_reg),
    .b_in(opb),
    .product(prod),
    .neg_out(neg_res),
    .neg_ov(n_ov),
    .neg_c(n_c),
    .neg_dc(n_dc),
    .neg_z(n_z)
  );

  // Indirect slot resolves through the pointer
  function [7:0] resolve;
    input [7:0] a;
    input [7:0] ptr;
    begin
      resolve = (a == `MMR_ADDR_INDF) ? ptr : a;
    end
  endfunction

  // Read of data space with the working register mapped in
  function [7:0] rd;
    input [7:0] a;
    input [7:0] w;
    input [7:0] m;
    begin
      rd = (a == `MMR_ADDR_WORKING_REG) ? w : m;
    end
  endfunction

  // ---------------------------------------------
  // Register bus and instruction execute
  // ---------------------------------------------
  always @(posedge core_clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MMR_RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `MMR_RESP_OKAY;
      s_axi_rdata <= 32'h0000_0000;
      aw_got <= 1'b0;
      w_got <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      working_reg <= 8'h00;
      bank_select_reg <= 8'h00;
      product_high <= 8'h00;
      product_low <= 8'h00;
      cpu_status_reg <= 8'h00;
      pc_high_latch <= 8'h00;
      pc <= 16'h0000;
      stack_top <= 16'h0000;
      indir_ptr <= 8'h00;
      {flag_ov, flag_c, flag_dc, flag_z} <= 4'h0;
      instr <= 16'h0000;
      phase <= `MMR_PH_DECODE;
      run <= 1'b0;
      refetch <= 1'b0;
      mem_addr <= 8'h00;
      opa <= 8'h00;
      opb <= 8'h00;
      busy <= 1'b0;
    end else begin
      s_axi_awready <= ~aw_got & ~aw_take & ~s_axi_bvalid;
      s_axi_wready <= ~w_got & ~w_take & ~s_axi_bvalid;
      // Ready stays up while idle so a waiting address is always taken
      s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
      if (aw_take) begin
        aw_got <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (s_axi_bvalid & s_axi_bready)
        s_axi_bvalid <= 1'b0;
      if (s_axi_rvalid & s_axi_rready)
        s_axi_rvalid <= 1'b0;
      busy <= run;
      // Execute: one phase per clock
      if (run) begin
        phase <= phase + 2'h1;
        case (phase)
          `MMR_PH_DECODE: begin
            opa <= resolve(f_fld, indir_ptr);
            opb <= resolve(p_fld, indir_ptr);
          end
          `MMR_PH_READ: begin
            if (is_mvpf)
              opb <= rd(opb, working_reg, mem[opb]);
            else if (is_mull | is_ldlw | is_return_with_literal | is_bankl | is_bankh)
              opb <= f_fld;
            else if (!is_mvfp)
              opb <= rd(opa, working_reg, mem[opa]);
            // Move to peripheral keeps its destination in opb
          end
          `MMR_PH_PROC: begin
            if (is_reti)
              cpu_status_reg[`MMR_GINTD_BIT] <= 1'b0;
          end
          `MMR_PH_WRITE: begin
            run <= 1'b0;
            refetch <= 1'b0;
            if (is_ldlw)
              working_reg <= opb;
            if (is_bankl)
              bank_select_reg[3:0] <= instr[3:0];
            if (is_bankh)
              bank_select_reg[7:4] <= instr[7:4];
            if (is_mull | is_mulf) begin
              product_high <= prod[15:8];
              product_low <= prod[7:0];
            end
            if (is_stwf) begin
              if (opa == `MMR_ADDR_WORKING_REG)
                working_reg <= working_reg;
              else
                mem[opa] <= working_reg;
            end
            if (is_mvfp) begin
              if (opb == `MMR_ADDR_WORKING_REG)
                working_reg <= opb == opa ? working_reg : rd(opa,
                  working_reg, mem[opa]);
              else
                mem[opb] <= rd(opa, working_reg, mem[opa]);
            end
            if (is_mvpf) begin
              flag_z <= (opb == 8'h00);
              if (opa == `MMR_ADDR_WORKING_REG)
                working_reg <= opb;
              else
                mem[opa] <= opb;
            end
            if (is_negate_w) begin
              if (opa != `MMR_ADDR_WORKING_REG)
                mem[opa] <= neg_res;
              if (!instr[8] || opa == `MMR_ADDR_WORKING_REG)
                working_reg <= neg_res;
              {flag_ov, flag_c, flag_dc, flag_z} <=
                {n_ov, n_c, n_dc, n_z};
            end
            if (is_return_with_literal)
              working_reg <= opb;
            if ((is_reti | is_return_with_literal) & ~refetch) begin
              pc <= stack_top;
              run <= 1'b1;
              refetch <= 1'b1;
              instr <= `MMR_OP_NOP;
            end else if (~refetch) begin
              pc <= pc + 16'h0001;
            end
          end
          default: phase <= `MMR_PH_DECODE;
        endcase
      end
      // Register writes
      if ((aw_got | aw_take) & (w_got | w_take) & ~s_axi_bvalid) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `MMR_RESP_OKAY;
        if (!(w_take ? s_axi_wstrb[0] : w_strb[0])) begin
          s_axi_bresp <= `MMR_RESP_OKAY;
        end else if (lat == `MMR_OFF_CTRL) begin
          if (k[0] & ~run) begin
            run <= 1'b1;
            phase <= `MMR_PH_DECODE;
          end
        end else if (lat == `MMR_OFF_INSTR & ~run) begin
          instr <= w_take ? s_axi_wdata[15:0] : w_data[15:0];
        end else if (lat == `MMR_OFF_WORKING_REG & ~run) begin
          working_reg <= k;
        end else if (lat == `MMR_OFF_BANK & ~run) begin
          bank_select_reg <= k;
        end else if (lat == `MMR_OFF_CPU_STATUS_REG & ~run) begin
          cpu_status_reg <= k;
        end else if (lat == `MMR_OFF_TOS & ~run) begin
          stack_top <= w_take ? s_axi_wdata[15:0] : w_data[15:0];
        end else if (lat == `MMR_OFF_MEMADDR & ~run) begin
          mem_addr <= k;
        end else if (lat == `MMR_OFF_MEMDATA & ~run) begin
          mem[mem_addr] <= k;
        end else if (lat == `MMR_OFF_INDIR & ~run) begin
          indir_ptr <= k;
        end else if (lat == `MMR_OFF_STATUS | lat == `MMR_OFF_PROD |
                     lat == `MMR_OFF_PC) begin
          s_axi_bresp <= `MMR_RESP_OKAY;
        end else begin
          s_axi_bresp <= `MMR_RESP_SLVERR;
        end
      end
      // Register reads
      if (s_axi_arvalid & s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `MMR_RESP_OKAY;
        case (s_axi_araddr)
          `MMR_OFF_CTRL: s_axi_rdata <= {31'h0, run};
          `MMR_OFF_INSTR: s_axi_rdata <= {16'h0000, instr};
          `MMR_OFF_STATUS: s_axi_rdata <= {27'h0, run, flag_ov,
            flag_c, flag_dc, flag_z};
          `MMR_OFF_WORKING_REG: s_axi_rdata <= {24'h0, working_reg};
          `MMR_OFF_BANK: s_axi_rdata <= {24'h0, bank_select_reg};
          `MMR_OFF_PROD: s_axi_rdata <= {16'h0, product_high,
            product_low};
          `MMR_OFF_CPU_STATUS_REG: s_axi_rdata <= {24'h0, cpu_status_reg};
          `MMR_OFF_PC: s_axi_rdata <= {8'h00, pc_high_latch, pc};
          `MMR_OFF_TOS: s_axi_rdata <= {16'h0000, stack_top};
          `MMR_OFF_MEMADDR: s_axi_rdata <= {24'h0, mem_addr};
          `MMR_OFF_MEMDATA: s_axi_rdata <= {24'h0, mem[mem_addr]};
          `MMR_OFF_INDIR: s_axi_rdata <= {24'h0, indir_ptr};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MMR_RESP_SLVERR;
          end
        endcase
      end
    end
  end
endmodule

// ===== mmr_core_monitor.sv
// Bus and execution timing checks for the execute block
`timescale 1ns/1ps
`include "mmr_defines.vh"
module mmr_core_monitor (
  input wire core_clk,
  input wire rst_n,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write resp dropped");
  property p_rlat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rlat: assert property (p_rlat) else $error("read answer late");
  property p_rsrc;
    $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready);
  endproperty
  a_rsrc: assert property (p_rsrc) else $error("read answer unasked");
  property p_rst;
    $rose(rst_n) |-> !s_axi_bvalid && !s_axi_rvalid && !busy;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs live in reset");
  property p_bsymin;
    $rose(busy) |-> busy[*3];
  endproperty
  a_bsymin: assert property (p_bsymin) else $error("cycle too short");
  property p_bsyend;
    $rose(busy) |-> ##[3:9] !busy;
  endproperty
  a_bsyend: assert property (p_bsyend) else $error("cycle too long");
  property p_err0;
    s_axi_rvalid && s_axi_rresp == `MMR_RESP_SLVERR |-> s_axi_rdata == 32'h0;
  endproperty
  a_err0: assert property (p_err0) else $error("error read not zero");
  property p_bcode;
    s_axi_bvalid |-> s_axi_bresp == `MMR_RESP_OKAY ||
      s_axi_bresp == `MMR_RESP_SLVERR;
  endproperty
  a_bcode: assert property (p_bcode) else $error("bad write resp");
endmodule
bind mmr_core mmr_core_monitor i_mon (.core_clk, .rst_n, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .busy);

// ===== tb.sv
// Bus-driven bench for the execute block
`timescale 1ns/1ps
`include "mmr_defines.vh"
module tb;
  logic core_clk, rst_n, awv, wv, bq, arv, rq;
  logic [7:0] awa, ara;
  logic [3:0] ws;
  logic [31:0] wd, rdat, pc0;
  logic [1:0] rsp;
  wire awr, wrd, bv, arr, rv, bsy;
  wire [1:0] br, rr;
  wire [31:0] rdv;
  integer fails, samples_checked;
  mmr_core i_dut (.core_clk, .rst_n, .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
    .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rdv), .s_axi_rresp(rr), .s_axi_rvalid(rv),
    .s_axi_rready(rq), .busy(bsy));
  initial begin
    core_clk = 1'h0;
    forever #4 core_clk = ~core_clk;
  end
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task tmo;
    fails = fails + 1;
    $display("[ERR] handshake exp 1 got 0");
    end_sim;
  endtask
  task chk(input string s, input [31:0] g, input [31:0] e);
    samples_checked = samples_checked + 1;
    if (g !== e) begin
      fails = fails + 1;
      $display("[ERR] %s exp %h got %h", s, e, g);
    end
  endtask
  task axw(input [7:0] a, input [31:0] v);
    integer n;
    @(posedge core_clk);
    awa <= a;
    wd <= v;
    awv <= 1'h1;
    wv <= 1'h1;
    bq <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (awr) awv <= 1'h0;
      if (wrd) wv <= 1'h0;
      n = n + 1;
    end while (bv !== 1'h1 && n < 40);
    rsp = br;
    bq <= 1'h0;
    if (n >= 40) tmo;
  endtask
  task axr(input [7:0] a, output [31:0] v);
    integer n;
    @(posedge core_clk);
    ara <= a;
    arv <= 1'h1;
    rq <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      if (arr) arv <= 1'h0;
      n = n + 1;
    end while (rv !== 1'h1 && n < 40);
    v = rdv;
    rsp = rr;
    rq <= 1'h0;
    if (n >= 40) tmo;
  endtask
  task rc(input string s, input [7:0] a, input [31:0] e);
    axr(a, rdat);
    chk(s, rdat, e);
  endtask
  task mw(input [7:0] a, input [7:0] v);
    axw(`MMR_OFF_MEMADDR, {24'h0, a});
    axw(`MMR_OFF_MEMDATA, {24'h0, v});
  endtask
  task mc(input string s, input [7:0] a, input [31:0] e);
    axw(`MMR_OFF_MEMADDR, {24'h0, a});
    rc(s, `MMR_OFF_MEMDATA, e);
  endtask
  task ex(input [15:0] i);
    integer n;
    axw(`MMR_OFF_INSTR, {16'h0, i});
    axw(`MMR_OFF_CTRL, 32'h1);
    n = 0;
    do begin
      axr(`MMR_OFF_CTRL, rdat);
      n = n + 1;
    end while (rdat[0] !== 1'h0 && n < 20);
    if (n >= 20) tmo;
  endtask
  initial begin
    fails = 0;
    samples_checked = 0;
    rst_n = 1'h0;
    {awv, wv, bq, arv, rq} = 5'h0;
    {awa, ara, wd} = 48'h0;
    ws = 4'hF;
    repeat (4) @(posedge core_clk);
    rst_n <= 1'h1;
    @(posedge core_clk);
    ex(16'hB03A);
    ex(16'h2D42);
    mc("neg file", 8'h42, 32'hC6);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'h3A);
    rc("stat", `MMR_OFF_STATUS, 32'h00);
    ex(16'hB080);
    ex(16'h2C41);
    mc("neg file", 8'h41, 32'h80);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'h80);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    ex(16'hB05A);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'h5A);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    $display("test negate and literal done");
    ex(16'hB0E2);
    ex(16'hBCC4);
    rc("prod", `MMR_OFF_PROD, 32'hAD08);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'hE2);
    ex(16'hB0C4);
    mw(8'h40, 8'hB5);
    ex(16'h3440);
    rc("prod", `MMR_OFF_PROD, 32'h8A94);
    mc("mul file", 8'h40, 32'hB5);
    ex(16'hBC00);
    rc("prod", `MMR_OFF_PROD, 32'h0);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    ex(16'h01FF);
    mc("store", 8'hFF, 32'hC4);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    $display("test multiply and store done");
    ex(16'hB802);
    ex(16'hBA20);
    rc("bank", `MMR_OFF_BANK, 32'h22);
    ex(16'hB805);
    rc("bank", `MMR_OFF_BANK, 32'h25);
    ex(16'hBB50);
    rc("bank", `MMR_OFF_BANK, 32'h55);
    ex(16'hB8F0);
    rc("bank", `MMR_OFF_BANK, 32'h50);
    $display("test bank done");
    mw(8'h1F, 8'h00);
    ex(16'h5F50);
    mc("mvpf", 8'h50, 32'h00);
    rc("stat", `MMR_OFF_STATUS, 32'h0B);
    mw(8'h1F, 8'h11);
    ex(16'h5F50);
    mc("mvpf", 8'h50, 32'h11);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    ex(16'h4A51);
    mc("working_reg src", 8'h51, 32'hC4);
    axw(`MMR_OFF_INDIR, 32'h60);
    ex(16'h6050);
    mc("ind p", 8'h60, 32'h11);
    ex(16'h7E00);
    mc("ind f", 8'h1E, 32'h11);
    $display("test moves done");
    axr(`MMR_OFF_PC, pc0);
    ex(16'h0000);
    rc("pc", `MMR_OFF_PC, pc0 + 32'h1);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'hC4);
    rc("stat", `MMR_OFF_STATUS, 32'h0A);
    rc("bank", `MMR_OFF_BANK, 32'h50);
    axw(`MMR_OFF_CPU_STATUS_REG, 32'h10);
    axw(`MMR_OFF_TOS, 32'h1234);
    axr(`MMR_OFF_PC, pc0);
    ex(16'h0005);
    rc("pc", `MMR_OFF_PC, {pc0[31:16], 16'h1234});
    rc("cpu_status_reg", `MMR_OFF_CPU_STATUS_REG, 32'h0);
    rc("instr", `MMR_OFF_INSTR, 32'h0);
    axw(`MMR_OFF_TOS, 32'h0ABC);
    ex(16'hB607);
    rc("working_reg", `MMR_OFF_WORKING_REG, 32'h07);
    rc("pc", `MMR_OFF_PC, {pc0[31:16], 16'h0ABC});
    $display("test returns done");
    axr(8'h30, rdat);
    chk("rd resp", {30'h0, rsp}, {30'h0, `MMR_RESP_SLVERR});
    axw(8'h30, 32'h5);
    chk("wr resp", {30'h0, rsp}, {30'h0, `MMR_RESP_SLVERR});
    $display("test unmapped done");
    end_sim;
  end
endmodule
